// ===== src/abx_exec.sv
// Execution datapath for add, AND and bit-clear instructions
`timescale 1ns/1ps
module abx_exec
  import abx_pkg::*;
#(
  parameter int DATA_W = ABX_DATA_W
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Instruction from decoder
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  // File register read port
  output logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  input wire logic file_is_port,
  // Port pin levels, asynchronous
  input wire logic [7:0] port_pins,
  // File register write port
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  // Core state
  output logic [7:0] acc,
  output logic flag_carry,
  output logic digit_carry_flag,
  output logic flag_zero,
  // Execution status
  output logic done,
  output logic unsupported
);

  if (DATA_W != ABX_DATA_W) begin : g_bad_width
    $error("abx_exec supports only an 8-bit data path");
  end

  // Decode the instruction word into one operation
  function automatic abx_op_t abx_decode(input logic [13:0] iw);
    abx_op_t op;
    op = ABX_OP_NONE;
    if (iw[ABX_LIT_OP_MSB:ABX_ADD_LIT_LSB] == ABX_OPC_ADD_LIT) begin
      op = ABX_OP_ADD_LIT;
    end else if (iw[ABX_LIT_OP_MSB:ABX_LIT_OP_LSB] == ABX_OPC_AND_LIT) begin
      op = ABX_OP_AND_LIT;
    end else if (iw[ABX_LIT_OP_MSB:ABX_LIT_OP_LSB] == ABX_OPC_ADD_FILE) begin
      op = ABX_OP_ADD_FILE;
    end else if (iw[ABX_LIT_OP_MSB:ABX_LIT_OP_LSB] == ABX_OPC_AND_FILE) begin
      op = ABX_OP_AND_FILE;
    end else if (iw[ABX_LIT_OP_MSB:ABX_CLR_BIT_LSB] == ABX_OPC_CLR_BIT) begin
      op = ABX_OP_CLR_BIT;
    end
    return op;
  endfunction

  // Eight-bit add with carry and digit carry
  function automatic logic [9:0] abx_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] sum;
    logic [4:0] nib;
    sum = {1'b0, a} + {1'b0, b};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {sum[8], nib[ABX_NIB_W], sum[7:0]};
  endfunction

  logic [7:0] acc_r;
  abx_flags_t flags_r;
  abx_fwr_t fwr_r;
  logic done_r;
  logic unsup_r;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_s3_r;
  logic [7:0] pin_lvl_r;

  abx_op_t op;
  logic [6:0] faddr;
  logic [2:0] bsel;
  logic dest;
  logic [7:0] lit;
  logic [7:0] fop;
  logic [9:0] add_lit;
  logic [9:0] add_file;
  logic [7:0] result;
  logic res_to_file;
  logic [7:0] acc_nxt;
  abx_flags_t flags_nxt;
  abx_fwr_t fwr_nxt;

  assign op = abx_decode(instr_word);
  assign faddr = instr_word[ABX_BIT_LSB-1:ABX_FILE_LSB];
  assign bsel = instr_word[ABX_CLR_BIT_LSB-1:ABX_BIT_LSB];
  assign dest = instr_word[ABX_DEST_POS];
  assign lit = instr_word[ABX_LIT_OP_LSB-1:ABX_LIT_LSB];
  assign file_raddr = faddr;

  // Pin synchroniser, three stages
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_r <= ABX_PIN_RST;
      pin_s2_r <= ABX_PIN_RST;
      pin_s3_r <= ABX_PIN_RST;
    end else if (ce) begin
      pin_s1_r <= port_pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Accept a pin change once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_lvl_r <= ABX_PIN_RST;
    end else if (ce) begin
      for (int i = 0; i < ABX_DATA_W; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_lvl_r[i] <= pin_s3_r[i];
        end
      end
    end
  end

  // File operand selection
  always_comb begin
    fop = file_rdata;
    if (file_is_port) begin
      fop = pin_lvl_r;
    end else if (fwr_r.we && fwr_r.addr == faddr) begin
      fop = fwr_r.data; // Forward pending write
    end
  end

  assign add_lit = abx_add(acc_r, lit);
  assign add_file = abx_add(acc_r, fop);

  // Execute one instruction
  always_comb begin
    result = ABX_ACC_RST;
    res_to_file = 1'b0;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    case (op)
      ABX_OP_ADD_LIT: begin
        acc_nxt = add_lit[7:0];
        flags_nxt.carry = add_lit[9];
        flags_nxt.digit_carry_flag = add_lit[8];
        flags_nxt.zero = (add_lit[7:0] == 8'h00);
      end
      ABX_OP_AND_LIT: begin
        acc_nxt = acc_r & lit;
        flags_nxt.zero = ((acc_r & lit) == 8'h00);
      end
      ABX_OP_ADD_FILE: begin
        result = add_file[7:0];
        flags_nxt.carry = add_file[9];
        flags_nxt.digit_carry_flag = add_file[8];
        flags_nxt.zero = (add_file[7:0] == 8'h00);
        res_to_file = (dest == ABX_DEST_FILE);
        if (dest == ABX_DEST_ACC) begin
          acc_nxt = result;
        end
      end
      ABX_OP_AND_FILE: begin
        result = acc_r & fop;
        flags_nxt.zero = (result == 8'h00);
        res_to_file = (dest == ABX_DEST_FILE);
        if (dest == ABX_DEST_ACC) begin
          acc_nxt = result;
        end
      end
      ABX_OP_CLR_BIT: begin
        result = fop & ~(8'h01 << bsel);
        res_to_file = 1'b1;
      end
      default: begin
        result = ABX_ACC_RST;
      end
    endcase
  end

  // File write request
  always_comb begin
    fwr_nxt = ABX_FWR_RST;
    if (instr_valid && res_to_file) begin
      fwr_nxt.we = 1'b1;
      fwr_nxt.addr = faddr;
      fwr_nxt.data = result;
    end
  end

  // Accumulator and flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_r <= ABX_ACC_RST;
      flags_r <= ABX_FLAGS_RST;
    end else if (ce && instr_valid) begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
    end
  end

  // File write port, one-cycle request
  always_ff @(posedge mclk) begin
    if (rst) begin
      fwr_r <= ABX_FWR_RST;
    end else if (ce) begin
      fwr_r <= fwr_nxt;
    end
  end

  // Completion and unsupported opcode pulses
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_r <= 1'b0;
      unsup_r <= 1'b0;
    end else if (ce) begin
      done_r <= instr_valid && (op != ABX_OP_NONE);
      unsup_r <= instr_valid && (op == ABX_OP_NONE);
    end
  end

  assign file_we = fwr_r.we;
  assign file_waddr = fwr_r.addr;
  assign file_wdata = fwr_r.data;
  assign acc = acc_r;
  assign flag_carry = flags_r.carry;
  assign digit_carry_flag = flags_r.digit_carry_flag;
  assign flag_zero = flags_r.zero;
  assign done = done_r;
  assign unsupported = unsup_r;

endmodule

// ===== src/abx_pkg.sv
// Shared constants and types for the add and bit-clear execution datapath
package abx_pkg;
  localparam int ABX_DATA_W = 8;
  localparam int ABX_INSTR_W = 14;
  localparam int ABX_ADDR_W = 7;
  localparam int ABX_BIT_W = 3;
  // Opcode field positions and patterns
  localparam int ABX_LIT_OP_MSB = 13;
  localparam int ABX_LIT_OP_LSB = 8;
  localparam int ABX_ADD_LIT_LSB = 9;
  localparam logic [4:0] ABX_OPC_ADD_LIT = 5'h1F;
  localparam logic [5:0] ABX_OPC_AND_LIT = 6'h39;
  localparam logic [5:0] ABX_OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] ABX_OPC_AND_FILE = 6'h05;
  localparam int ABX_CLR_BIT_LSB = 10;
  localparam logic [3:0] ABX_OPC_CLR_BIT = 4'h4;
  // Operand field positions and nibble width
  localparam int ABX_DEST_POS = 7;
  localparam int ABX_BIT_LSB = 7;
  localparam int ABX_FILE_LSB = 0;
  localparam int ABX_LIT_LSB = 0;
  localparam int ABX_NIB_W = 4;
  // Destination select values
  localparam logic ABX_DEST_ACC = 1'h0;
  localparam logic ABX_DEST_FILE = 1'h1;
  // Reset values
  localparam logic [7:0] ABX_ACC_RST = 8'h00;
  localparam logic [7:0] ABX_PIN_RST = 8'h00;
  // Decoded operation, one-hot
  typedef enum logic [5:0] {
    ABX_OP_NONE = 6'h01,
    ABX_OP_ADD_LIT = 6'h02,
    ABX_OP_AND_LIT = 6'h04,
    ABX_OP_ADD_FILE = 6'h08,
    ABX_OP_AND_FILE = 6'h10,
    ABX_OP_CLR_BIT = 6'h20
  } abx_op_t;
  // Status flags
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } abx_flags_t;
  localparam abx_flags_t ABX_FLAGS_RST = 3'h0;
  // File register write request
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } abx_fwr_t;
  localparam abx_fwr_t ABX_FWR_RST = 16'h0000;
endpackage

// ===== tb/abx_exec_assertions.sv
// Checker of the execution datapath port behaviour
`timescale 1ns/1ps
module abx_exec_assertions
  import abx_pkg::*;
(
  // Clock, reset, instruction
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  // File and pins
  input wire logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  input wire logic file_is_port,
  input wire logic [7:0] port_pins,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  // Core state and status
  input wire logic [7:0] acc,
  input wire logic flag_carry,
  input wire logic digit_carry_flag,
  input wire logic flag_zero,
  input wire logic done,
  input wire logic unsupported
);
  logic go;
  logic ok;
  logic [13:0] w;
  // Taken instruction, operand read straight from the file
  assign go = ce && instr_valid && !rst;
  assign ok = !file_is_port && !(file_we && file_waddr == file_raddr);
  assign w = instr_word;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_ADD_LIT:
  assert property (go && w[13:9] == 5'h1F |=> flag_zero == (acc == 8'h00)
    && {flag_carry, acc} == 9'($past(acc)) + 9'($past(w[7:0])))
    else $error("add literal result wrong");
  AST_AND_LIT:
  assert property (go && w[13:8] == 6'h39 |=>
    acc == ($past(acc) & $past(w[7:0])) && $stable(flag_carry))
    else $error("and literal result wrong");
  AST_ADD_FILE:
  assert property (go && ok && w[13:7] == 7'h0E |=>
    {flag_carry, acc} == 9'($past(acc)) + 9'($past(file_rdata)))
    else $error("add file result wrong");
  AST_DEST_FILE:
  assert property (go && w[13:12] == 2'h0 && w[7] && w[11:8] inside {4'h5,
    4'h7} |=> file_we && file_waddr == $past(w[6:0]) && $stable(acc))
    else $error("file destination not written");
  AST_AND_FILE:
  assert property (go && ok && w[13:7] == 7'h0B |=> $stable(flag_carry) &&
    file_wdata == ($past(acc) & $past(file_rdata)))
    else $error("and file result wrong");
  AST_CLR_BIT:
  assert property (go && ok && w[13:10] == 4'h4 |=>
    file_wdata == ($past(file_rdata) & ~(8'h01 << $past(w[9:7])))
    && $stable({flag_carry, digit_carry_flag, flag_zero}))
    else $error("bit clear result wrong");
  AST_ONE_CYCLE:
  assert property (ce |=> (done ^ unsupported) == $past(go))
    else $error("completion pulse wrong");
  AST_FILE_ADDR:
  assert property (go |-> file_raddr == w[6:0])
    else $error("file read address wrong");
  AST_PORT_PIN:
  assert property ((ce && $stable(port_pins)) [*6] ##0 (go && file_is_port
    && w[13:10] == 4'h4) |=>
    file_wdata == ($past(port_pins) & ~(8'h01 << $past(w[9:7]))))
    else $error("port operand not from pins");
endmodule
bind abx_exec abx_exec_assertions u_chk (.mclk, .rst, .ce, .instr_valid,
  .instr_word, .file_raddr, .file_rdata, .file_is_port, .port_pins, .file_we,
  .file_waddr, .file_wdata, .acc, .flag_carry, .digit_carry_flag, .flag_zero,
  .done, .unsupported);

// ===== tb/abx_file_model.sv
// Register file model with asynchronous read and one port location
`timescale 1ns/1ps
module abx_file_model (
  // Clock
  input wire logic mclk,
  // Read port
  input wire logic [6:0] file_raddr,
  output logic [7:0] file_rdata,
  output logic file_is_port,
  // Write port
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];
  // Each location starts holding its own address
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i);
    end
  end
  // Write lands at the edge ending the strobe cycle
  always @(posedge mclk) begin
    if (file_we) begin
      mem[file_waddr] <= file_wdata;
    end
  end
  // Port at 06 is flagged so the datapath takes the synchronised pins, not this latch
  assign file_rdata = mem[file_raddr];
  assign file_is_port = (file_raddr == 7'h06);
endmodule

// ===== tb/add_and_bitclear_exec_bench.sv
// Self-checking bench for the add and bit-clear execution datapath
`timescale 1ns/1ps
module add_and_bitclear_exec_bench;
  logic mclk = 0, rst = 1, ce = 1, instr_valid = 0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] port_pins = 8'hF0;
  logic [6:0] file_raddr, file_waddr;
  logic [7:0] file_rdata, file_wdata, acc;
  logic file_is_port, file_we, flag_carry, digit_carry_flag, flag_zero;
  logic done, unsupported;
  logic [28:0] seen;
  int n_errors = 0, compares = 0, cyc = 0;
  // Word, then acc, carry, digit carry, zero, strobe, address, data, pulses
  logic [42:0] rows [14] = '{
    {14'h3E10, 8'h10, 3'h0, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h3E15, 8'h25, 3'h0, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h3FDB, 8'h00, 3'h7, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h395F, 8'h00, 3'h7, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h3EA3, 8'hA3, 3'h0, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h395F, 8'h03, 3'h0, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h077F, 8'h82, 3'h2, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h07FE, 8'h82, 3'h7, 1'h1, 7'h7E, 8'h00, 2'h2},
    {14'h1147, 8'h82, 3'h7, 1'h1, 7'h47, 8'h43, 2'h2},
    {14'h0747, 8'hC5, 3'h0, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h0585, 8'hC5, 3'h0, 1'h1, 7'h05, 8'h05, 2'h2},
    {14'h0542, 8'h40, 3'h0, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h053F, 8'h00, 3'h1, 1'h0, 7'h00, 8'h00, 2'h2},
    {14'h3800, 8'h00, 3'h1, 1'h0, 7'h00, 8'h00, 2'h1}};
  // Observed bundle in row order
  assign seen = {acc, flag_carry, digit_carry_flag, flag_zero, file_we,
    file_waddr, file_wdata, done, unsupported};
  // Clock
  always #12.5 mclk = ~mclk;
  abx_exec u_abx_exec (.mclk, .rst, .ce, .instr_valid, .instr_word,
    .file_raddr, .file_rdata, .file_is_port, .port_pins, .file_we,
    .file_waddr, .file_wdata, .acc, .flag_carry, .digit_carry_flag,
    .flag_zero, .done, .unsupported);
  abx_file_model u_abx_file_model (.mclk, .file_raddr, .file_rdata,
    .file_is_port, .file_we, .file_waddr, .file_wdata);
  // Compare and report
  task chk(input string n, input logic [28:0] s, input logic [28:0] x);
    compares++;
    if (s !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // Verdict and end of run
  task finish_test;
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      finish_test;
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge mclk);
    rst = 0;
    chk("reset", seen, 29'h0);
    instr_valid = 1;
    foreach (rows[i]) begin
      instr_word = rows[i][42:29];
      @(negedge mclk);
      chk("row", seen, rows[i][28:0]);
    end
    instr_valid = 0;
    @(negedge mclk);
    ce = 0;
    instr_valid = 1;
    instr_word = 14'h3E01;
    @(negedge mclk);
    chk("freeze", seen, {8'h00, 3'h1, 18'h0});
    ce = 1;
    instr_valid = 0;
    repeat (6) @(negedge mclk);
    instr_valid = 1;
    instr_word = 14'h1206;
    @(negedge mclk);
    instr_valid = 0;
    chk("pins", seen, {8'h00, 3'h1, 1'h1, 7'h06, 8'hE0, 2'h2});
    port_pins = 8'h3C;
    instr_valid = 1;
    @(negedge mclk);
    instr_valid = 0;
    chk("pin lag", seen, {8'h00, 3'h1, 1'h1, 7'h06, 8'hE0, 2'h2});
    repeat (4) @(negedge mclk);
    instr_valid = 1;
    @(negedge mclk);
    instr_valid = 0;
    chk("pin new", seen, {8'h00, 3'h1, 1'h1, 7'h06, 8'h2C, 2'h2});
    rst = 1;
    @(negedge mclk);
    rst = 0;
    chk("rerun", seen, 29'h0);
    finish_test;
  end
endmodule
